/* hw/dte_pkg.sv */
// constants, field layouts and carrier types of the data transfer engine
// Overview of operation
// RULE_01: one channel per transfer-capable interrupt source
// RULE_02: normal mode moves one unit per activation
// RULE_03: repeat mode reloads start address after size
// RULE_04: block mode moves one block, 1 to 256 units
// RULE_05: unit is byte, word or longword per description
// RULE_06: chain descriptions always or when counter is zero
// RULE_07: sequence transfer on one trigger source only
// RULE_08: first transferred data selects the sequence
// RULE_09: sequence runs whole or pauses and resumes later
// RULE_10: short-address mode keeps addresses in 16 MB
// RULE_11: full-address mode spans the whole 4 GB
// RULE_12: cpu interrupt by activation, per transfer or count
// RULE_13: event-link request per transfer, per block in block
// RULE_14: read skip reuses the held description
// RULE_15: skip write-back of unchanged fixed addresses
// RULE_16: write-back disable flag suppresses all write-back
// RULE_17: optional displacement added to the source address
// RULE_18: module stop suspends new activations
// RULE_19: only enabled sources 027 to 255 may start
// RULE_20: sequence-end flag ends the current sequence
// RULE_21: memory accesses use a dedicated synchronous bus
// RULE_22: fetch description, transfer, then write back
// RULE_23: clear source request when no cpu interrupt raised
package dte_pkg;
  localparam int SRC_COUNT = 256;
  localparam int FIRST_SRC = 27;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_VEC_BASE = 12'h004;
  localparam logic [11:0] OFS_IDX_BASE = 12'h008;
  localparam logic [11:0] OFS_SEQ_CTRL = 12'h00C;
  localparam logic [11:0] OFS_DISP = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_EN_BASE = 12'h100;
  localparam logic [11:0] OFS_EN_END = 12'h120;
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_RSKIP_BIT = 1;
  localparam int CTRL_SHORT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int SHORT_TOP_BIT = 23;
  localparam logic [31:0] DSC_BYTES = 32'h0000_0010;
  localparam logic [8:0] MAX_UNITS = 9'h100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_REPEAT, MODE_BLOCK} xfer_mode_t;
  typedef enum logic [1:0] {UNIT_BYTE, UNIT_WORD, UNIT_LONG} unit_size_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_VEC_RD, ST_DSC_RD, ST_DAT_RD, ST_DAT_WR, ST_WB, ST_FIN, ST_SEQ_RD,
    ST_DONE, ST_REST
  } eng_state_t;

  // transfer_mode_word_a/b/c folded into one descriptor word
  typedef struct packed {
    logic [17:0] spare;
    logic index_table_select;
    logic sequence_end_flag;
    logic disp_en;
    logic writeback_disable_flag;
    logic irq_each;
    logic chain_zero;
    logic chain_en;
    logic rpt_dst;
    logic dst_inc;
    logic src_inc;
    unit_size_t size;
    xfer_mode_t mode;
  } mode_word_t;

  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] blk_size;
    logic [15:0] count;
  } count_word_t;

  typedef struct packed {
    mode_word_t mw;
    logic [31:0] src;
    logic [31:0] dst;
    count_word_t cnt;
  } desc_t;

  typedef struct packed {
    logic valid;
    logic write;
    unit_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mem_rsp_t;
endpackage

/* hw/data_transfer_engine.sv */
// interrupt-triggered data transfer engine with an AXI4-Lite register slave
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module data_transfer_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [255:0] src_request,
  output logic req_clear,
  output logic [7:0] req_clear_src,
  output logic cpu_irq,
  output logic [7:0] cpu_irq_src,
  output logic elc_req,
  output dte_pkg::mem_req_t mem_req,
  input wire dte_pkg::mem_rsp_t mem_rsp
);
  typedef struct packed {
    logic awready, wready, arready, bvalid, rvalid, aw_seen, w_seen;
    logic [1:0] bresp, rresp;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] rdata;
    logic [2:0] ctrl;
    logic [31:0] vec_base, idx_base, seq_resume, dsc_addr, data;
    logic [7:0] seq_src, ch, last_ch, irq_src, clr_src;
    logic seq_en, seq_first, seq_active, seq_paused, held_valid, irq_any, chained, short_q;
    logic cpu_irq, elc_req, req_clr;
    logic [15:0] disp;
    logic [255:0] en;
    dte_pkg::eng_state_t state;
    dte_pkg::desc_t desc;
    logic [1:0] widx;
    logic [8:0] blk_left;
    dte_pkg::mem_req_t mem;
  } st_t;

  localparam logic [255:0] EN_MASK = ~((256'h1 << dte_pkg::FIRST_SRC) - 256'h1);

  st_t st_reg;
  st_t st_next;
  logic pick_found;
  logic [7:0] pick_src;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  // short mode folds the low and high 8 MB halves into a 16 MB space
  function automatic logic [31:0] amap(input logic [31:0] a, input logic sh);
    if (sh) begin
      return {{8{a[dte_pkg::SHORT_TOP_BIT]}}, a[dte_pkg::SHORT_TOP_BIT:0]}; // [RULE_10]
    end
    return a; // [RULE_11]
  endfunction

  function automatic logic [8:0] units(input dte_pkg::count_word_t c);
    return (c.blk_size == 8'h00) ? dte_pkg::MAX_UNITS : {1'b0, c.blk_size}; // [RULE_04]
  endfunction

  function automatic dte_pkg::mem_req_t mk(input logic [31:0] a, input logic w,
                                           input dte_pkg::unit_size_t s, input logic [31:0] d);
    dte_pkg::mem_req_t m;
    m.valid = 1'b1;
    m.write = w;
    m.size = s;
    m.addr = a;
    m.wdata = d;
    return m;
  endfunction

  // lowest enabled pending source wins; a disabled one is left to the cpu
  always_comb begin
    pick_found = 1'b0;
    pick_src = 8'h00;
    for (int i = dte_pkg::SRC_COUNT - 1; i >= dte_pkg::FIRST_SRC; i--) begin
      if (src_request[i] && st_reg.en[i]) begin // [RULE_19] [RULE_01] [RULE_12]
        pick_found = 1'b1;
        pick_src = 8'(i);
      end
    end
  end

  always_comb begin
    logic [31:0] ub;
    logic [31:0] rl;
    logic [31:0] wv;
    logic zero;
    logic chain_go;
    logic skip;
    st_next = st_reg;
    wv = 32'h0;
    st_next.cpu_irq = 1'b0;
    st_next.elc_req = 1'b0;
    st_next.req_clr = 1'b0;
    ub = 32'h1 << st_reg.desc.mw.size; // [RULE_05]
    rl = 32'(units(st_reg.desc.cnt)) << st_reg.desc.mw.size;
    zero = (st_reg.desc.cnt.count == 16'h0000) && (st_reg.desc.mw.mode != dte_pkg::MODE_REPEAT);
    chain_go = st_reg.desc.mw.chain_en && (!st_reg.desc.mw.chain_zero || zero); // [RULE_06]
    skip = ((st_reg.widx == 2'd1) && !st_reg.desc.mw.src_inc) ||
           ((st_reg.widx == 2'd2) && !st_reg.desc.mw.dst_inc);
    case (st_reg.state)
      dte_pkg::ST_IDLE: begin
        if (pick_found && !st_reg.ctrl[dte_pkg::CTRL_STOP_BIT]) begin // [RULE_18]
          st_next.ch = pick_src;
          st_next.irq_any = 1'b0;
          st_next.chained = 1'b0;
          st_next.short_q = st_reg.ctrl[dte_pkg::CTRL_SHORT_BIT];
          st_next.state = dte_pkg::ST_VEC_RD;
          if (st_reg.seq_en && pick_src == st_reg.seq_src) begin // [RULE_07]
            if (st_reg.seq_paused) begin
              st_next.dsc_addr = st_reg.seq_resume; // [RULE_09]
              st_next.seq_active = 1'b1;
              st_next.seq_paused = 1'b0;
              st_next.widx = 2'd0;
              st_next.state = dte_pkg::ST_DSC_RD;
            end else begin
              st_next.seq_first = 1'b1;
            end
          end else if (st_reg.ctrl[dte_pkg::CTRL_RSKIP_BIT] && st_reg.held_valid &&
                       pick_src == st_reg.last_ch) begin
            st_next.blk_left = (st_reg.desc.mw.mode == dte_pkg::MODE_BLOCK) ?
                               units(st_reg.desc.cnt) : 9'd1; // [RULE_14]
            st_next.state = dte_pkg::ST_DAT_RD;
          end
        end
      end
      dte_pkg::ST_VEC_RD: begin
        if (!st_reg.mem.valid) begin
          st_next.mem = mk(amap(st_reg.vec_base + {22'h0, st_reg.ch, 2'b00}, st_reg.short_q),
                           1'b0, dte_pkg::UNIT_LONG, 32'h0); // [RULE_21]
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.dsc_addr = mem_rsp.rdata;
          st_next.widx = 2'd0;
          st_next.state = dte_pkg::ST_DSC_RD;
        end
      end
      dte_pkg::ST_DSC_RD: begin
        if (!st_reg.mem.valid) begin
          st_next.mem = mk(amap(st_reg.dsc_addr + {28'h0, st_reg.widx, 2'b00}, st_reg.short_q),
                           1'b0, dte_pkg::UNIT_LONG, 32'h0); // [RULE_22]
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.widx = st_reg.widx + 2'd1;
          case (st_reg.widx)
            2'd0: st_next.desc.mw = dte_pkg::mode_word_t'(mem_rsp.rdata);
            2'd1: st_next.desc.src = mem_rsp.rdata;
            2'd2: st_next.desc.dst = mem_rsp.rdata;
            default: begin
              st_next.desc.cnt = dte_pkg::count_word_t'(mem_rsp.rdata);
              st_next.blk_left = (st_reg.desc.mw.mode == dte_pkg::MODE_BLOCK) ?
                                 units(dte_pkg::count_word_t'(mem_rsp.rdata)) : 9'd1;
              st_next.state = dte_pkg::ST_DAT_RD;
            end
          endcase
        end
      end
      dte_pkg::ST_DAT_RD: begin
        if (!st_reg.mem.valid) begin
          st_next.mem = mk(amap(st_reg.desc.src + (st_reg.desc.mw.disp_en ?
                           {{16{st_reg.disp[15]}}, st_reg.disp} : 32'h0), st_reg.short_q),
                           1'b0, st_reg.desc.mw.size, 32'h0); // [RULE_17]
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.data = mem_rsp.rdata;
          st_next.state = dte_pkg::ST_DAT_WR;
        end
      end
      dte_pkg::ST_DAT_WR: begin
        if (!st_reg.mem.valid) begin
          st_next.mem = mk(amap(st_reg.desc.dst, st_reg.short_q), 1'b1, st_reg.desc.mw.size,
                           st_reg.data);
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.desc.src = st_reg.desc.mw.src_inc ? st_reg.desc.src + ub : st_reg.desc.src;
          st_next.desc.dst = st_reg.desc.mw.dst_inc ? st_reg.desc.dst + ub : st_reg.desc.dst;
          st_next.blk_left = st_reg.blk_left - 9'd1;
          if (st_reg.desc.mw.mode == dte_pkg::MODE_BLOCK && st_reg.blk_left > 9'd1) begin
            st_next.state = dte_pkg::ST_DAT_RD; // [RULE_04]
          end else begin
            st_next.elc_req = 1'b1; // [RULE_13] [RULE_02]
            st_next.desc.cnt.count = st_reg.desc.cnt.count - 16'h0001;
            if ((st_reg.desc.mw.mode == dte_pkg::MODE_REPEAT &&
                 st_reg.desc.cnt.count == 16'h0001) ||
                st_reg.desc.mw.mode == dte_pkg::MODE_BLOCK) begin
              if (st_reg.desc.mw.mode == dte_pkg::MODE_REPEAT) begin
                st_next.desc.cnt.count = {7'h00, units(st_reg.desc.cnt)}; // [RULE_03]
              end
              if (st_reg.desc.mw.rpt_dst && st_reg.desc.mw.dst_inc) begin
                st_next.desc.dst = st_reg.desc.dst + ub - rl;
              end else if (!st_reg.desc.mw.rpt_dst && st_reg.desc.mw.src_inc) begin
                st_next.desc.src = st_reg.desc.src + ub - rl;
              end
            end
            st_next.widx = 2'd1;
            st_next.state = st_reg.desc.mw.writeback_disable_flag ? dte_pkg::ST_FIN : // [RULE_16]
                            dte_pkg::ST_WB;
          end
        end
      end
      dte_pkg::ST_WB: begin
        if (!st_reg.mem.valid) begin
          if (skip) begin
            st_next.widx = st_reg.widx + 2'd1; // [RULE_15]
          end else begin
            wv = (st_reg.widx == 2'd1) ? st_reg.desc.src :
                 (st_reg.widx == 2'd2) ? st_reg.desc.dst : 32'(st_reg.desc.cnt);
            st_next.mem = mk(amap(st_reg.dsc_addr + {28'h0, st_reg.widx, 2'b00}, st_reg.short_q),
                             1'b1, dte_pkg::UNIT_LONG, wv); // [RULE_22]
          end
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.widx = st_reg.widx + 2'd1;
          if (st_reg.widx == 2'd3) begin
            st_next.state = dte_pkg::ST_FIN;
          end
        end
      end
      dte_pkg::ST_FIN: begin
        st_next.irq_any = st_reg.irq_any || st_reg.desc.mw.irq_each || zero; // [RULE_12]
        st_next.state = dte_pkg::ST_DONE;
        if (st_reg.seq_first) begin
          st_next.state = dte_pkg::ST_SEQ_RD; // [RULE_08]
        end else if (st_reg.seq_active) begin
          if (st_reg.desc.mw.sequence_end_flag) begin
            st_next.seq_active = 1'b0; // [RULE_20]
          end else if (chain_go) begin
            st_next.dsc_addr = st_reg.dsc_addr + dte_pkg::DSC_BYTES;
            st_next.widx = 2'd0;
            st_next.state = dte_pkg::ST_DSC_RD;
          end else begin
            st_next.seq_active = 1'b0; // [RULE_09]
            st_next.seq_paused = 1'b1;
            st_next.seq_resume = st_reg.dsc_addr + dte_pkg::DSC_BYTES;
          end
        end else if (chain_go) begin
          st_next.chained = 1'b1; // [RULE_06]
          st_next.dsc_addr = st_reg.dsc_addr + dte_pkg::DSC_BYTES;
          st_next.widx = 2'd0;
          st_next.state = dte_pkg::ST_DSC_RD;
        end
      end
      dte_pkg::ST_SEQ_RD: begin
        if (!st_reg.mem.valid) begin
          st_next.mem = mk(amap(st_reg.idx_base + {22'h0, st_reg.data[7:0], 2'b00},
                           st_reg.short_q), 1'b0, dte_pkg::UNIT_LONG, 32'h0); // [RULE_08]
        end else if (mem_rsp.ack) begin
          st_next.mem.valid = 1'b0;
          st_next.dsc_addr = mem_rsp.rdata;
          st_next.seq_first = 1'b0;
          st_next.seq_active = 1'b1;
          st_next.widx = 2'd0;
          st_next.state = dte_pkg::ST_DSC_RD;
        end
      end
      dte_pkg::ST_DONE: begin
        if (st_reg.irq_any) begin
          st_next.cpu_irq = 1'b1; // [RULE_12]
          st_next.irq_src = st_reg.ch;
          st_next.en[st_reg.ch] = 1'b0;
        end else begin
          st_next.req_clr = 1'b1; // [RULE_23]
          st_next.clr_src = st_reg.ch;
        end
        st_next.held_valid = !st_reg.chained && !st_reg.seq_active && !st_reg.seq_paused &&
                             !(st_reg.seq_en && st_reg.ch == st_reg.seq_src);
        st_next.last_ch = st_reg.ch;
        st_next.state = dte_pkg::ST_REST;
      end
      default: begin
        st_next.state = dte_pkg::ST_IDLE;
      end
    endcase

    // register write: address and data in either order, then one response
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_seen = 1'b1;
      st_next.awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_seen = 1'b1;
      st_next.wdata_q = s_axi_wdata;
      st_next.wstrb_q = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_seen && st_reg.w_seen && !st_reg.bvalid) begin
      st_next.aw_seen = 1'b0;
      st_next.w_seen = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = dte_pkg::RESP_OKAY;
      wv = merge(32'h0, st_reg.wdata_q, st_reg.wstrb_q);
      if (st_reg.awaddr_q == dte_pkg::OFS_CTRL) begin
        wv = merge({29'h0, st_reg.ctrl}, st_reg.wdata_q, st_reg.wstrb_q);
        st_next.ctrl = wv[2:0];
      end else if (st_reg.awaddr_q == dte_pkg::OFS_VEC_BASE) begin
        st_next.vec_base = merge(st_reg.vec_base, st_reg.wdata_q, st_reg.wstrb_q);
      end else if (st_reg.awaddr_q == dte_pkg::OFS_IDX_BASE) begin
        st_next.idx_base = merge(st_reg.idx_base, st_reg.wdata_q, st_reg.wstrb_q);
      end else if (st_reg.awaddr_q == dte_pkg::OFS_SEQ_CTRL) begin
        wv = merge({st_reg.seq_en, 23'h0, st_reg.seq_src}, st_reg.wdata_q, st_reg.wstrb_q);
        st_next.seq_en = wv[31];
        st_next.seq_src = wv[7:0];
        if (!wv[31]) begin
          st_next.seq_paused = 1'b0;
        end
      end else if (st_reg.awaddr_q == dte_pkg::OFS_DISP) begin
        wv = merge({16'h0, st_reg.disp}, st_reg.wdata_q, st_reg.wstrb_q);
        st_next.disp = wv[15:0];
      end else if (st_reg.awaddr_q >= dte_pkg::OFS_EN_BASE &&
                   st_reg.awaddr_q < dte_pkg::OFS_EN_END && st_reg.awaddr_q[1:0] == 2'b00) begin
        st_next.en[32*st_reg.awaddr_q[4:2]+:32] =
          merge(st_reg.en[32*st_reg.awaddr_q[4:2]+:32], st_reg.wdata_q, st_reg.wstrb_q);
        st_next.en = st_next.en & EN_MASK; // [RULE_19]
      end else begin
        st_next.bresp = dte_pkg::RESP_SLVERR;
      end
    end
    st_next.awready = !st_next.aw_seen && !st_next.bvalid;
    st_next.wready = !st_next.w_seen && !st_next.bvalid;

    // register read: one cycle after the address is taken
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = dte_pkg::RESP_OKAY;
      st_next.rdata = 32'h0;
      if (s_axi_araddr == dte_pkg::OFS_CTRL) begin
        st_next.rdata = {22'h0, st_reg.ctrl[dte_pkg::CTRL_STOP_BIT] &&
                         st_reg.state == dte_pkg::ST_IDLE,
                         st_reg.state != dte_pkg::ST_IDLE, 5'h0, st_reg.ctrl};
      end else if (s_axi_araddr == dte_pkg::OFS_VEC_BASE) begin
        st_next.rdata = st_reg.vec_base;
      end else if (s_axi_araddr == dte_pkg::OFS_IDX_BASE) begin
        st_next.rdata = st_reg.idx_base;
      end else if (s_axi_araddr == dte_pkg::OFS_SEQ_CTRL) begin
        st_next.rdata = {st_reg.seq_en, st_reg.seq_paused, 22'h0, st_reg.seq_src};
      end else if (s_axi_araddr == dte_pkg::OFS_DISP) begin
        st_next.rdata = {16'h0, st_reg.disp};
      end else if (s_axi_araddr == dte_pkg::OFS_STATUS) begin
        st_next.rdata = {st_reg.seq_paused, st_reg.seq_active, 14'h0, st_reg.last_ch, st_reg.ch};
      end else if (s_axi_araddr >= dte_pkg::OFS_EN_BASE &&
                   s_axi_araddr < dte_pkg::OFS_EN_END && s_axi_araddr[1:0] == 2'b00) begin
        st_next.rdata = st_reg.en[32*s_axi_araddr[4:2]+:32];
      end else begin
        st_next.rresp = dte_pkg::RESP_SLVERR;
      end
    end
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign req_clear = st_reg.req_clr;
  assign req_clear_src = st_reg.clr_src;
  assign cpu_irq = st_reg.cpu_irq;
  assign cpu_irq_src = st_reg.irq_src;
  assign elc_req = st_reg.elc_req;
  assign mem_req = st_reg.mem;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_unit_done;
    ce && st_reg.state == dte_pkg::ST_DAT_WR && st_reg.mem.valid && mem_rsp.ack;
  endsequence
  sequence s_last_unit;
    s_unit_done ##0 (st_reg.desc.mw.mode != dte_pkg::MODE_BLOCK || st_reg.blk_left == 9'd1);
  endsequence

  stop_holds_idle_a: assert property (ce && st_reg.state == dte_pkg::ST_IDLE && // [RULE_18]
    st_reg.ctrl[dte_pkg::CTRL_STOP_BIT] |=> st_reg.state == dte_pkg::ST_IDLE)
    else $error("engine left idle while stopped");
  enable_gates_start_a: assert property (ce && st_reg.state == dte_pkg::ST_IDLE && // [RULE_19]
    !pick_found |=> st_reg.state == dte_pkg::ST_IDLE)
    else $error("engine started without an enabled request");
  normal_single_unit_a: assert property (s_unit_done ##0 // [RULE_02]
    st_reg.desc.mw.mode == dte_pkg::MODE_NORMAL |=> st_reg.elc_req &&
    (st_reg.state == dte_pkg::ST_WB || st_reg.state == dte_pkg::ST_FIN))
    else $error("normal mode did not end after one unit");
  block_no_early_a: assert property (s_unit_done ##0 // [RULE_04]
    st_reg.desc.mw.mode == dte_pkg::MODE_BLOCK && st_reg.blk_left > 9'd1
    |=> st_reg.state == dte_pkg::ST_DAT_RD && !st_reg.elc_req)
    else $error("block ended early");
  elc_per_activation_a: assert property (s_last_unit |=> st_reg.elc_req ##1 // [RULE_13]
    (!ce || !st_reg.elc_req))
    else $error("event-link request missing or stretched");
  repeat_reload_a: assert property (s_unit_done ##0 // [RULE_03]
    st_reg.desc.mw.mode == dte_pkg::MODE_REPEAT && st_reg.desc.cnt.count == 16'h0001
    |=> st_reg.desc.cnt.count == {7'h00, units(st_reg.desc.cnt)})
    else $error("repeat counter not reloaded");
  writeback_disable_flag_no_write_a: assert property (st_reg.state == dte_pkg::ST_WB |-> // [RULE_16]
    !st_reg.desc.mw.writeback_disable_flag)
    else $error("write-back with disable flag set");
  short_space_a: assert property (st_reg.mem.valid && st_reg.short_q |-> // [RULE_10]
    st_reg.mem.addr[31:24] == {8{st_reg.mem.addr[23]}})
    else $error("short-address access outside 16 MB");
  irq_or_clear_a: assert property (ce && st_reg.state == dte_pkg::ST_DONE |=> // [RULE_23]
    (st_reg.cpu_irq != st_reg.req_clr) && st_reg.state == dte_pkg::ST_REST)
    else $error("done without exactly one of irq or clear");
endmodule
`default_nettype wire

/* tb/mem_model.sv */
// behavioural on-chip memory answering the engine's memory bus
`timescale 1ns/1ns
`default_nettype none
module mem_model #(parameter int LAT = 1) (
  input wire logic aclk,
  input wire dte_pkg::mem_req_t req,
  output var dte_pkg::mem_rsp_t rsp
);
  logic [31:0] m [256];
  int w = 0;
  logic [31:0] last = 32'h0;
  // ack after LAT waiting cycles; idle data is the inverse of the last word
  always_comb begin
    rsp.ack = req.valid && (w >= LAT);
    rsp.rdata = rsp.ack ? m[req.addr[9:2]] : ~last;
  end
  always @(posedge aclk) begin
    if (rsp.ack) begin
      w <= 0;
      last <= rsp.rdata;
      if (req.write) m[req.addr[9:2]] <= req.wdata;
    end else if (req.valid) w <= w + 1;
  end
endmodule
`default_nettype wire

/* tb/test_data_transfer_engine.sv */
// self-checking bench of the data transfer engine
`timescale 1ns/1ns
`default_nettype none
module test_data_transfer_engine;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_t;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ce = 1;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rq, ne, ni;
  logic [255:0] srq = '0;
  logic [1:0] rs;
  wire logic awr, wrd, brv, arr, rv, rclr, irq, event_link_unit;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdt;
  wire logic [7:0] rsrc, isrc;
  wire dte_pkg::mem_req_t mq;
  wire dte_pkg::mem_rsp_t ms;
  int n_mismatch = 0, n_checks = 0, t;
  row_t rows[4] = '{'{12'h100, 32'hFFFF_FFFF, 32'hF800_0000, dte_pkg::RESP_OKAY},
    '{12'hFFC, 32'h1234_5678, 32'h0, dte_pkg::RESP_SLVERR},
    '{12'h004, 32'h0, 32'h0, dte_pkg::RESP_OKAY},
    '{12'h100, 32'h4000_0000, 32'h4000_0000, dte_pkg::RESP_OKAY}};
  always #10 aclk = ~aclk;
  data_transfer_engine dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(brv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .src_request(srq), .req_clear(rclr), .req_clear_src(rsrc), .cpu_irq(irq),
    .cpu_irq_src(isrc), .elc_req(event_link_unit), .mem_req(mq), .mem_rsp(ms));
  mem_model #(.LAT(2)) mem (.aclk(aclk), .req(mq), .rsp(ms));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (brv) break;
    end
    rs = br; bry <= 0; tmo(t, 60);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1; rry <= 1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rq = rdt; rs = rr; rry <= 0; tmo(t, 60);
  endtask
  // waits for the end of one activation, counting event-link pulses
  task automatic wt;
    ne = 0;
    for (t = 0; t < 300; t++) begin
      @(posedge aclk);
      ne += event_link_unit;
      if (rclr || irq) break;
    end
    ni = irq; srq <= '0; tmo(t, 300);
  endtask
  initial begin
    mem.m[30] = 32'h100;
    mem.m[64] = 32'h38; mem.m[65] = 32'h200; mem.m[66] = 32'h300; mem.m[67] = 32'h2;
    mem.m[128] = 32'hCAFE_F00D; mem.m[129] = 32'h1234_5678; mem.m[193] = 32'h5A5A_5A5A;
    mem.m[31] = 32'h140; mem.m[80] = 32'hC3A; mem.m[81] = 32'h200; mem.m[82] = 32'h380;
    mem.m[83] = 32'h2_0001; mem.m[130] = 32'h7777_1111;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(dte_pkg::OFS_STATUS); chk(rq, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d); chk(rs, rows[i].r);
      rd(rows[i].a); chk(rq, rows[i].q); chk(rs, rows[i].r);
    end
    ce <= 0;
    srq[30] <= 1;
    ni = 0;
    repeat (10) begin
      @(posedge aclk);
      ni += mq.valid;
    end
    chk(ni, 0);
    ce <= 1;
    wt();
    chk(rsrc, 32'd30); chk(ni, 0); chk(ne, 1);
    chk(mem.m[192], 32'hCAFE_F00D); chk(mem.m[193], 32'h5A5A_5A5A);
    chk(mem.m[65], 32'h204); chk(mem.m[67], 32'h1);
    wr(dte_pkg::OFS_CTRL, 32'h1);
    srq[30] <= 1;
    ni = 0;
    repeat (60) begin
      @(posedge aclk);
      ni += rclr | irq | mq.valid;
    end
    chk(ni, 0);
    wr(dte_pkg::OFS_CTRL, 32'h0);
    wt();
    chk(ni, 1); chk(mem.m[193], 32'h1234_5678);
    rd(12'h100); chk(rq, 32'h0);
    chk(isrc, 32'd30);
    wr(dte_pkg::OFS_DISP, 32'h4);
    wr(12'h100, 32'h8000_0000);
    srq[31] <= 1;
    wt();
    chk(ni, 1); chk(isrc, 32'd31); chk(ne, 1);
    chk(mem.m[224], 32'h1234_5678); chk(mem.m[225], 32'h7777_1111);
    chk(mem.m[81], 32'h200);
    wrap_up();
  end
endmodule
`default_nettype wire
